// ===== device_config_pkg.sv
// Package for the device configuration register bank.
// Assumes a byte-addressed host port with accesses of 1 to 4 bytes inside one word.
package device_config_pkg;

  // ---------------------------------------------------------------
  // Byte offsets inside a channel window
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CHANNEL_SERVICE_FLAGS = 8'h80;
  localparam logic [7:0] OFS_IRQ_CODE_BYTE_ONE = 8'h81;
  localparam logic [7:0] OFS_TIMER_COMMAND = 8'h84;
  localparam logic [7:0] OFS_RESERVED_A = 8'h85;
  localparam logic [7:0] OFS_TIMER_PERIOD_LOW = 8'h86;
  localparam logic [7:0] OFS_TIMER_PERIOD_HIGH = 8'h87;
  localparam logic [7:0] OFS_OVERSAMPLE_BY8 = 8'h88;
  localparam logic [7:0] OFS_OVERSAMPLE_BY4 = 8'h89;
  localparam logic [7:0] OFS_CHANNEL_SOFT_RESET = 8'h8A;
  localparam logic [7:0] OFS_CHANNEL_SLEEP = 8'h8B;
  localparam logic [7:0] OFS_DEVICE_REVISION = 8'h8C;
  localparam logic [7:0] OFS_DEVICE_IDENTITY = 8'h8D;
  localparam logic [7:0] OFS_EEPROM_CONTROL = 8'h8E;
  localparam logic [7:0] OFS_PIN_IRQ_MASK_LOW = 8'h8F;
  localparam logic [7:0] OFS_PIN_LEVEL_LOW = 8'h90;
  localparam logic [7:0] OFS_PIN_TRISTATE_LOW = 8'h91;
  localparam logic [7:0] OFS_PIN_INVERT_LOW = 8'h92;
  localparam logic [7:0] OFS_PIN_SELECT_LOW = 8'h93;
  localparam logic [7:0] OFS_PIN_OPEN_DRAIN_LOW = 8'h94;
  localparam logic [7:0] OFS_PIN_IRQ_MASK_HIGH = 8'h95;
  localparam logic [7:0] OFS_PIN_LEVEL_HIGH = 8'h96;
  localparam logic [7:0] OFS_PIN_TRISTATE_HIGH = 8'h97;
  localparam logic [7:0] OFS_PIN_INVERT_HIGH = 8'h98;
  localparam logic [7:0] OFS_PIN_SELECT_HIGH = 8'h99;
  localparam logic [7:0] OFS_PIN_OPEN_DRAIN_HIGH = 8'h9A;
  localparam logic [7:0] OFS_RESERVED_TAIL = 8'h9B;

  // Bank geometry: bytes 0x80..0x9B, window bit selects channel
  localparam int BANK_BYTES = 28;
  localparam int CHAN_SEL_BIT = 10;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PIN_SELECT = 8'hFF;

  // Field positions in the code byte: channel 0 low, channel 1 above it
  localparam int CODE_CH0_LSB = 0;
  localparam int CODE_CH1_LSB = 3;

  // Pin configuration carried to the pin block
  typedef struct packed {
    logic [15:0] irq_mask;
    logic [15:0] level;
    logic [15:0] tristate;
    logic [15:0] invert;
    logic [15:0] select;
    logic [15:0] open_drain;
  } pin_cfg_t;

  // Host access request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [10:0] addr;
    logic [1:0]  size;
    logic [31:0] wdata;
  } host_req_t;

endpackage : device_config_pkg

// ===== device_config_register_bank.sv
// Device configuration register bank, seen through both channel windows.
// Assumes the host port gives a byte address, a size (bytes minus one) and
// word-aligned data lanes; an access never crosses a word boundary.
//
// Overview of operation
// R1 - Four interrupt bytes read-only, reset zero
// R2 - Timer control, reserved, period bytes reset zero
// R3 - Per-channel bytes change only caller's bit
// R4 - Soft reset write-only, self clears after done
// R5 - Sleep byte read/write, bit per channel
// R6 - Pin interrupt mask low/high, reset zero
// R7 - Pin level control low/high, reset zero
// R8 - Pin tristate control low/high, reset zero
// R9 - Pin input inversion low/high, reset zero
// R10 - Pin open-drain enables low/high, reset zero
// R11 - Word access, lowest address in lane 0
// R12 - Pin select resets ones; tail reads zero
// R13 - Oversample bytes per channel; id bytes 8C-8D
// R14 - Accesses of 8, 16, 24, 32 bits
// R15 - Bank mirrored in both channel windows
// R16 - Wake after full sleep; byte0 read clears
`timescale 1ns/10ps
module device_config_register_bank
  import device_config_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h01, // Arbitrary value
  parameter logic [7:0] IDENTITY = 8'h5A  // Arbitrary value
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // Host access port
  input  device_config_pkg::host_req_t host_i,
  output logic        ack_o,
  output logic [31:0] rdata_o,
  // Interrupt sources from the channels
  input  wire logic [1:0] chan_irq_i,
  input  wire logic [5:0] chan_code_i,
  // Channel soft reset handshake
  input  wire logic [1:0] chan_reset_done_i,
  output logic [1:0] chan_reset_o,
  // Channel controls
  output logic [1:0] oversample_by8_o,
  output logic [1:0] oversample_by4_o,
  output logic [1:0] chan_sleep_o,
  output logic wake_irq_o,
  // Timer, EEPROM and pin configuration
  output logic [7:0] timer_command_o,
  output logic [15:0] timer_period_o,
  output logic [7:0] eeprom_control_o,
  output device_config_pkg::pin_cfg_t pin_cfg_o
);
  import device_config_pkg::*;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic        in_bank;
  logic        chan;
  logic [2:0]  word_idx;
  logic [2:0]  end_lane;
  logic [3:0]  lane_en;
  logic        wr;
  logic        rd;

  // Same bank answers in both windows; bit 10 only names the caller
  assign in_bank = (host_i.addr[9:5] == 5'b0_0100) && (host_i.addr[4:2] != 3'b111); // [R15]
  assign chan = host_i.addr[CHAN_SEL_BIT]; // [R3]
  assign word_idx = host_i.addr[4:2];
  // Starting lane plus size sets the covered lanes, clipped at the word end
  assign end_lane = {1'b0, host_i.addr[1:0]} + {1'b0, host_i.size}; // [R14]
  assign wr = host_i.req && host_i.we && in_bank;
  assign rd = host_i.req && !host_i.we && in_bank;

  // Lane enables, one per byte lane
  genvar l;
  generate
    for (l = 0; l < 4; l++) begin : g_lane
      assign lane_en[l] = (3'(l) >= {1'b0, host_i.addr[1:0]}) && (3'(l) <= end_lane); // [R14]
    end
  endgenerate

  // ---------------------------------------------------------------
  // Interrupt status bytes
  // ---------------------------------------------------------------
  logic [31:0] irq_q;
  logic [31:0] irq_d;

  // Sampled from the channels only; host writes never reach them
  assign irq_d = {16'h0000,
                  2'b00, chan_code_i[5:3], chan_code_i[2:0],
                  6'b00_0000, chan_irq_i};

  // Status capture
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= 32'h0000_0000; // [R1]
    end else begin
      irq_q <= irq_d; // [R1]
    end
  end

  // ---------------------------------------------------------------
  // Byte storage
  // ---------------------------------------------------------------
  logic [7:0] regs_q [BANK_BYTES];
  logic [7:0] rd_byte [BANK_BYTES];
  logic [BANK_BYTES-1:0] byte_wr;
  logic [7:0] own_bit;

  // Only the caller's bit is writable in the per-channel bytes
  assign own_bit = chan ? 8'h02 : 8'h01; // [R3]

  genvar b;
  generate
    for (b = 0; b < BANK_BYTES; b++) begin : g_byte
      localparam logic [7:0] OFS = 8'(8'h80 + b);
      localparam bit IS_CHAN = (OFS >= OFS_OVERSAMPLE_BY8) && (OFS <= OFS_CHANNEL_SLEEP);
      localparam bit IS_RO = (OFS <= OFS_IRQ_CODE_BYTE_ONE + 8'h02) ||
                             (OFS == OFS_RESERVED_A) || (OFS == OFS_DEVICE_REVISION) ||
                             (OFS == OFS_DEVICE_IDENTITY) || (OFS == OFS_RESERVED_TAIL);
      localparam logic [7:0] RST = ((OFS == OFS_PIN_SELECT_LOW) ||
                                    (OFS == OFS_PIN_SELECT_HIGH)) ? RST_PIN_SELECT : RST_ZERO;
      localparam logic [7:0] WMASK = IS_RO ? 8'h00 : 8'hFF;
      logic [7:0] wmask;
      logic [7:0] wbyte;
      logic [7:0] done_clr;
      logic [7:0] next;

      // Write decode for this byte
      assign byte_wr[b] = wr && (word_idx == 3'(b / 4)) && lane_en[b % 4];
      assign wmask = IS_CHAN ? own_bit : WMASK; // [R3]
      assign wbyte = host_i.wdata[8*(b%4) +: 8];
      // Soft reset bits drop once the channel reports the reset done
      assign done_clr = (OFS == OFS_CHANNEL_SOFT_RESET) ? {6'b00_0000, chan_reset_done_i}
                                                         : 8'h00; // [R4]
      // A new request in the same cycle as the done wins over the clear
      assign next = byte_wr[b] ? ((regs_q[b] & ~done_clr & ~wmask) | (wbyte & wmask))
                               : (regs_q[b] & ~done_clr); // [R4]

      // Byte register
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          regs_q[b] <= RST; // [R2] [R6] [R7] [R8] [R9] [R10] [R12] [R13]
        end else begin
          regs_q[b] <= next & WMASK;
        end
      end

      // Read value of this byte
      if (b < 4) begin : g_irq
        assign rd_byte[b] = irq_q[8*b +: 8]; // [R1] [R11]
      end else if (OFS == OFS_CHANNEL_SOFT_RESET) begin : g_wo
        assign rd_byte[b] = 8'h00; // [R4]
      end else if (OFS == OFS_DEVICE_REVISION) begin : g_rev
        assign rd_byte[b] = REVISION; // [R13]
      end else if (OFS == OFS_DEVICE_IDENTITY) begin : g_id
        assign rd_byte[b] = IDENTITY; // [R13]
      end else begin : g_rw
        assign rd_byte[b] = regs_q[b]; // [R5] [R12]
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  logic [31:0] rdata_d;
  logic [31:0] word_mux;

  // Lowest address lands in lane 0 of the word
  assign word_mux = {rd_byte[{word_idx, 2'b11}], rd_byte[{word_idx, 2'b10}],
                     rd_byte[{word_idx, 2'b01}], rd_byte[{word_idx, 2'b00}]}; // [R11]
  // Lanes outside the access and addresses outside the bank read zero
  assign rdata_d = rd ? (word_mux & {{8{lane_en[3]}}, {8{lane_en[2]}},
                                     {8{lane_en[1]}}, {8{lane_en[0]}}}) : 32'h0000_0000;

  // Answer one cycle after the request, for every request
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end else begin
      ack_o <= host_i.req; // [R14]
      rdata_o <= rdata_d; // [R11]
    end
  end

  // ---------------------------------------------------------------
  // Wake-up indicator
  // ---------------------------------------------------------------
  logic all_asleep_q;
  logic wake_set;
  logic wake_clr;

  // Wake after both channels were asleep and one leaves sleep
  assign wake_set = all_asleep_q && (regs_q[11][1:0] != 2'b11); // [R16]
  assign wake_clr = rd && (word_idx == 3'b000) && lane_en[0]; // [R16]

  // Sleep history and sticky wake flag; set beats clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      all_asleep_q <= 1'b0;
      wake_irq_o <= 1'b0;
    end else begin
      all_asleep_q <= (regs_q[11][1:0] == 2'b11);
      wake_irq_o <= wake_set || (wake_irq_o && !wake_clr); // [R16]
    end
  end

  // ---------------------------------------------------------------
  // Outputs taken straight from the byte registers
  // ---------------------------------------------------------------
  assign timer_command_o = regs_q[4]; // [R2]
  assign timer_period_o = {regs_q[7], regs_q[6]}; // [R2]
  assign oversample_by8_o = regs_q[8][1:0]; // [R13]
  assign oversample_by4_o = regs_q[9][1:0]; // [R13]
  assign chan_reset_o = regs_q[10][1:0]; // [R4]
  assign chan_sleep_o = regs_q[11][1:0]; // [R5]
  assign eeprom_control_o = regs_q[14];
  assign pin_cfg_o.irq_mask = {regs_q[21], regs_q[15]}; // [R6]
  assign pin_cfg_o.level = {regs_q[22], regs_q[16]}; // [R7]
  assign pin_cfg_o.tristate = {regs_q[23], regs_q[17]}; // [R8]
  assign pin_cfg_o.invert = {regs_q[24], regs_q[18]}; // [R9]
  assign pin_cfg_o.select = {regs_q[25], regs_q[19]}; // [R12]
  assign pin_cfg_o.open_drain = {regs_q[26], regs_q[20]}; // [R10]

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [1:0] sleep_prev;
  assign sleep_prev = regs_q[11][1:0];

  property p_status_tracks;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ##1 irq_q[7:0] == {6'b00_0000, $past(chan_irq_i)};
  endproperty
  a_status_tracks: assert property (p_status_tracks) // [R1]
    else $error("status byte does not follow channel flags");

  property p_period_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr && word_idx == 3'b001 && host_i.size == 2'b11 && host_i.addr[1:0] == 2'b00)
      |=> timer_period_o == $past(host_i.wdata[31:16]);
  endproperty
  a_period_write: assert property (p_period_write) // [R2]
    else $error("timer period not written");

  property p_other_chan_kept;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr && word_idx == 3'b010 && lane_en[3] && !chan)
      |=> chan_sleep_o[1] == $past(chan_sleep_o[1]);
  endproperty
  a_other_chan_kept: assert property (p_other_chan_kept) // [R3]
    else $error("other channel sleep bit changed");

  property p_reset_read_zero;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd && word_idx == 3'b010 && lane_en[2]) |=> ack_o && rdata_o[23:16] == 8'h00;
  endproperty
  a_reset_read_zero: assert property (p_reset_read_zero) // [R4]
    else $error("soft reset byte readable");

  property p_reset_self_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (chan_reset_o[0] && chan_reset_done_i[0] && !byte_wr[10]) |=> !chan_reset_o[0];
  endproperty
  a_reset_self_clear: assert property (p_reset_self_clear) // [R4]
    else $error("soft reset bit did not clear");

  property p_sleep_own_bit;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr && word_idx == 3'b010 && lane_en[3] && chan)
      |=> chan_sleep_o[1] == $past(host_i.wdata[25]);
  endproperty
  a_sleep_own_bit: assert property (p_sleep_own_bit) // [R5]
    else $error("sleep bit not written by own channel");

  property p_ack_latency;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      host_i.req |=> ack_o ##1 (ack_o == $past(host_i.req));
  endproperty
  a_ack_latency: assert property (p_ack_latency) // [R14]
    else $error("answer not one cycle after request");

  property p_tail_zero;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd && word_idx == 3'b110 && lane_en[3]) |=> rdata_o[31:24] == 8'h00;
  endproperty
  a_tail_zero: assert property (p_tail_zero) // [R12]
    else $error("reserved tail byte not zero");

  property p_wake_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wake_clr && !wake_set) |=> !wake_irq_o;
  endproperty
  a_wake_clear: assert property (p_wake_clear) // [R16]
    else $error("wake flag survived status read");

  property p_wake_set;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ($past(sleep_prev) == 2'b11 && sleep_prev != 2'b11) |=> wake_irq_o;
  endproperty
  a_wake_set: assert property (p_wake_set) // [R16]
    else $error("wake flag not raised");

  property p_code_bytes;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ##1 irq_q[31:8] == {16'h0000, 2'b00, $past(chan_code_i)};
  endproperty
  a_code_bytes: assert property (p_code_bytes) // [R1]
    else $error("interrupt code bytes do not follow channels");

  property p_timer_command_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr && word_idx == 3'b001 && lane_en[0])
      |=> timer_command_o == $past(host_i.wdata[7:0]);
  endproperty
  a_timer_command_write: assert property (p_timer_command_write) // [R2]
    else $error("timer command byte not written");

  property p_reserved_a_zero;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd && word_idx == 3'b001 && lane_en[1]) |=> rdata_o[15:8] == 8'h00;
  endproperty
  a_reserved_a_zero: assert property (p_reserved_a_zero) // [R2]
    else $error("reserved timer byte not zero");

  property p_pin_mask_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr && word_idx == 3'b011 && lane_en[3])
      |=> pin_cfg_o.irq_mask[7:0] == $past(host_i.wdata[31:24]);
  endproperty
  a_pin_mask_write: assert property (p_pin_mask_write) // [R6]
    else $error("pin interrupt mask not written");

  property p_pin_level_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr && word_idx == 3'b100 && lane_en[0])
      |=> pin_cfg_o.level[7:0] == $past(host_i.wdata[7:0]);
  endproperty
  a_pin_level_write: assert property (p_pin_level_write) // [R7]
    else $error("pin level byte not written");

  property p_pin_tristate_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr && word_idx == 3'b101 && lane_en[3])
      |=> pin_cfg_o.tristate[15:8] == $past(host_i.wdata[31:24]);
  endproperty
  a_pin_tristate_write: assert property (p_pin_tristate_write) // [R8]
    else $error("pin tristate byte not written");

  property p_pin_invert_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr && word_idx == 3'b110 && lane_en[0])
      |=> pin_cfg_o.invert[15:8] == $past(host_i.wdata[7:0]);
  endproperty
  a_pin_invert_write: assert property (p_pin_invert_write) // [R9]
    else $error("pin invert byte not written");

  property p_open_drain_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr && word_idx == 3'b101 && lane_en[0])
      |=> pin_cfg_o.open_drain[7:0] == $past(host_i.wdata[7:0]);
  endproperty
  a_open_drain_write: assert property (p_open_drain_write) // [R10]
    else $error("pin open-drain byte not written");

  property p_status_word_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd && word_idx == 3'b000 && host_i.size == 2'b11 && host_i.addr[1:0] == 2'b00)
      |=> rdata_o == $past(irq_q);
  endproperty
  a_status_word_read: assert property (p_status_word_read) // [R11]
    else $error("status word lanes out of order");

  property p_by4_own_bit;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr && word_idx == 3'b010 && lane_en[1] && !chan)
      |=> oversample_by4_o == {$past(oversample_by4_o[1]), $past(host_i.wdata[8])};
  endproperty
  a_by4_own_bit: assert property (p_by4_own_bit) // [R13]
    else $error("oversample by4 bit not written by own channel");

  property p_outside_ignored;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (host_i.req && host_i.we && !in_bank)
      |=> pin_cfg_o == $past(pin_cfg_o) && timer_period_o == $past(timer_period_o);
  endproperty
  a_outside_ignored: assert property (p_outside_ignored) // [R15]
    else $error("write outside the bank changed a register");

endmodule : device_config_register_bank

// ===== test_device_config_register_bank.sv
// Self-checking bench for the device configuration register bank.
// Assumes the bank package is compiled first; the bench drives all ports itself.
`timescale 1ns/10ps
module test_device_config_register_bank
  import device_config_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals, model and bookkeeping
  // ----------------------------------------------------------------
  localparam logic [7:0] REV = 8'h3C; // Arbitrary value
  localparam logic [7:0] IDV = 8'h6E; // Arbitrary value
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  host_req_t host = '0;
  logic ack_o;
  logic [31:0] rdata_o;
  logic [1:0] chan_irq_i = 2'b00;
  logic [5:0] chan_code_i = 6'h00;
  logic [1:0] chan_reset_done_i = 2'b00;
  logic [1:0] chan_reset_o, oversample_by8_o, oversample_by4_o, chan_sleep_o;
  logic wake_irq_o;
  logic [7:0] timer_command_o, eeprom_control_o;
  logic [15:0] timer_period_o;
  pin_cfg_t pin_cfg_o;
  logic [7:0] m [0:27];
  logic [1:0] sr;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  device_config_register_bank #(.REVISION(REV), .IDENTITY(IDV)) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .host_i(host), .ack_o(ack_o),
    .rdata_o(rdata_o), .chan_irq_i(chan_irq_i), .chan_code_i(chan_code_i),
    .chan_reset_done_i(chan_reset_done_i), .chan_reset_o(chan_reset_o),
    .oversample_by8_o(oversample_by8_o), .oversample_by4_o(oversample_by4_o),
    .chan_sleep_o(chan_sleep_o), .wake_irq_o(wake_irq_o),
    .timer_command_o(timer_command_o), .timer_period_o(timer_period_o),
    .eeprom_control_o(eeprom_control_o), .pin_cfg_o(pin_cfg_o));

  // Clock, plus a cycle ceiling so a lost answer cannot hang the run
  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles >= 4000) begin
      mismatches++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One request, answer looked at in its single ack cycle
  task automatic access(input logic we, input logic [10:0] a, input logic [1:0] sz,
                        input logic [31:0] wd);
    @(posedge core_clk_i);
    host <= '{req: 1'b1, we: we, addr: a, size: sz, wdata: wd};
    @(posedge core_clk_i);
    host.req <= 1'b0;
    #1;
    check({31'h0, ack_o}, 32'h1);
  endtask : access

  function automatic bit in_bank(input logic [10:0] a);
    return a[9:5] == 5'b00100 && a[4:2] != 3'b111;
  endfunction : in_bank

  function automatic int hi_lane(input logic [10:0] a, input logic [1:0] sz);
    return (int'(a[1:0]) + int'(sz) > 3) ? 3 : int'(a[1:0]) + int'(sz);
  endfunction : hi_lane

  // Writes update the model by access kind; bank bytes 80-83,85,8C,8D,9B ignore writes
  task automatic wr(input logic [10:0] a, input logic [1:0] sz, input logic [31:0] wd);
    logic [4:0] i;
    logic [7:0] b;
    access(1'b1, a, sz, wd);
    if (in_bank(a)) for (int l = a[1:0]; l <= hi_lane(a, sz); l++) begin
      i = {a[4:2], 2'(l)};
      b = wd[8*l +: 8];
      case (i)
        0, 1, 2, 3, 5, 12, 13, 27: ;
        8, 9, 11: m[i][a[10]] = b[a[10]];
        10: if (b[a[10]]) sr[a[10]] = 1'b1;
        default: m[i] = b;
      endcase
    end
  endtask : wr

  task automatic rd(input logic [10:0] a, input logic [1:0] sz);
    logic [31:0] e;
    logic [7:0] b;
    e = '0;
    access(1'b0, a, sz, 32'h0000_0000);
    for (int l = a[1:0]; l <= hi_lane(a, sz); l++) begin
      case ({a[4:2], 2'(l)})
        0: b = {6'h00, chan_irq_i};
        1: b = {2'b00, chan_code_i};
        2, 3, 10: b = 8'h00;
        default: b = m[{a[4:2], 2'(l)}];
      endcase
      e[8*l +: 8] = in_bank(a) ? b : 8'h00;
    end
    // Lanes outside the access must read zero too
    check(rdata_o, e);
  endtask : rd

  task automatic rd_all(input logic ch);
    for (int w = 0; w < 7; w++) rd({ch, 10'h080} + 11'(4 * w), 2'd3);
  endtask : rd_all

  task automatic check_outputs();
    check({24'h0, timer_command_o}, {24'h0, m[4]});
    check({16'h0, timer_period_o}, {16'h0, m[7], m[6]});
    check({24'h0, eeprom_control_o}, {24'h0, m[14]});
    check({28'h0, oversample_by8_o, oversample_by4_o}, {28'h0, m[8][1:0], m[9][1:0]});
    check({28'h0, chan_sleep_o, chan_reset_o}, {28'h0, m[11][1:0], sr});
    check({16'h0, pin_cfg_o.irq_mask}, {16'h0, m[21], m[15]});
    check({16'h0, pin_cfg_o.level}, {16'h0, m[22], m[16]});
    check({16'h0, pin_cfg_o.tristate}, {16'h0, m[23], m[17]});
    check({16'h0, pin_cfg_o.invert}, {16'h0, m[24], m[18]});
    check({pin_cfg_o.select, pin_cfg_o.open_drain}, {m[25], m[19], m[26], m[20]});
  endtask : check_outputs

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_values_test();
    foreach (m[k]) m[k] = 8'h00;
    m[12] = REV;
    m[13] = IDV;
    m[19] = 8'hFF;
    m[25] = 8'hFF;
    sr = 2'b00;
    check_outputs();
    check({31'h0, wake_irq_o}, 32'h0);
    rd_all(1'b0);
    rd_all(1'b1);
  endtask : reset_values_test

  // Every byte written alone from channel 0, read-only places included
  task automatic byte_write_test();
    for (int i = 0; i < 28; i++) wr(11'h080 + 11'(i), 2'd0, {4{8'hC3 ^ 8'(i)}});
    check_outputs();
    rd_all(1'b1);
  endtask : byte_write_test

  // Odd starts and widths, lanes past 3 dropped, accesses outside the bank
  task automatic width_test();
    wr(11'h490, 2'd3, 32'h1234_5678);
    wr(11'h484, 2'd3, 32'hBEEF_5A3C);
    wr(11'h096, 2'd1, 32'hA5C3_0000);
    wr(11'h499, 2'd3, 32'h7E81_66FF);
    wr(11'h09C, 2'd3, 32'hFFFF_FFFF);
    wr(11'h010, 2'd3, 32'hFFFF_FFFF);
    rd(11'h093, 2'd0);
    rd(11'h095, 2'd1);
    rd(11'h481, 2'd2);
    rd(11'h09B, 2'd3);
    rd(11'h09C, 2'd3);
    rd(11'h410, 2'd3);
    rd_all(1'b0);
    check_outputs();
  endtask : width_test

  // Own-bit writes, then sleep of both channels and the wake that follows
  task automatic channel_bit_test();
    wr(11'h488, 2'd1, 32'h0000_FFFF);
    wr(11'h088, 2'd1, 32'h0000_0000);
    wr(11'h08B, 2'd0, 32'hFF00_0000);
    wr(11'h48B, 2'd0, 32'hFF00_0000);
    check_outputs();
    check({31'h0, wake_irq_o}, 32'h0);
    wr(11'h08B, 2'd0, 32'h0000_0000);
    @(posedge core_clk_i);
    #1;
    check({31'h0, wake_irq_o}, 32'h1);
    rd(11'h088, 2'd3);
    rd(11'h080, 2'd0);
    check({31'h0, wake_irq_o}, 32'h0);
  endtask : channel_bit_test

  // Pending soft resets stay until done, read back as zero
  task automatic soft_reset_test();
    wr(11'h48A, 2'd0, 32'h0002_0000);
    check({30'h0, chan_reset_o}, 32'h3);
    rd(11'h48A, 2'd0);
    @(posedge core_clk_i);
    chan_reset_done_i <= 2'b11;
    @(posedge core_clk_i);
    chan_reset_done_i <= 2'b00;
    #1;
    sr = 2'b00;
    check({30'h0, chan_reset_o}, 32'h0);
  endtask : soft_reset_test

  // Live status seen in one word read, writes to it ignored
  task automatic status_test();
    @(posedge core_clk_i);
    chan_irq_i <= 2'b11;
    chan_code_i <= 6'b101_011;
    repeat (3) @(posedge core_clk_i);
    wr(11'h080, 2'd3, 32'hFFFF_FFFF);
    rd(11'h080, 2'd3);
    rd(11'h481, 2'd0);
  endtask : status_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    reset_values_test();
    byte_write_test();
    width_test();
    channel_bit_test();
    soft_reset_test();
    status_test();
    stop_test();
  end
endmodule : test_device_config_register_bank
